//--- logic/cotd_pkg.sv
// Types shared by the op unit and its timing lookup.
package cotd_pkg;

  typedef enum logic [2:0] {
    alu_none, byte_swap_op, sign_extend_op, test_zero_op, xor_op
  } cotd_alu_t;

  typedef enum logic [1:0] {
    fmt_single, fmt_jump, fmt_double, fmt_event
  } cotd_fmt_t;

  // The shift class covers arith_right_shift_op, rotate_right_carry_op,
  // byte_swap_op and sign_extend_op, which share one timing column.
  typedef enum logic [1:0] {cls_shift, cls_push, cls_call} cotd_cls_t;

  typedef enum logic [1:0] {
    ev_return_from_interrupt_op, ev_irq_accept, ev_watchdog_timer_reset,
    ev_pin_reset
  } cotd_ev_t;

  typedef enum logic [2:0] {
    src_reg, src_ind, src_ainc, src_imm, src_idx, src_sym, src_abs
  } cotd_src_t;

  typedef enum logic [2:0] {
    dst_reg, dst_program_counter, dst_idx, dst_sym, dst_abs
  } cotd_dst_t;

  typedef enum logic {st_idle, st_exec} cotd_state_t;

  typedef struct packed {
    cotd_fmt_t fmt;
    logic [1:0] sub;
    cotd_src_t src;
    cotd_dst_t dst;
  } cotd_desc_t;

  typedef struct packed {
    logic valid;
    logic [2:0] cycles;
    logic [1:0] words;
    logic undef;
  } cotd_time_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } cotd_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } cotd_wb_rsp_t;

endpackage

//--- logic/cotd_regs.svh
// Register offsets, field positions, reset values and cycle counts.
`ifndef COTD_REGS_SVH
`define COTD_REGS_SVH

// Register byte offsets on the bus.
`define COTD_OFS_CTRL 8'h00
`define COTD_OFS_SRC 8'h04
`define COTD_OFS_DST 8'h08
`define COTD_OFS_SRIN 8'h0C
`define COTD_OFS_RES 8'h10
`define COTD_OFS_SROUT 8'h14
`define COTD_OFS_TIME 8'h18
`define COTD_OFS_STAT 8'h1C

// Control register fields.
`define COTD_F_OP 2:0
`define COTD_F_BYTE 3
`define COTD_F_DESC 13:4
`define COTD_F_START 16
`define COTD_CTRL_W 14
`define COTD_CTRL_RST 14'h0000

// Status register bit positions and reset value.
`define COTD_SR_C 0
`define COTD_SR_Z 1
`define COTD_SR_N 2
`define COTD_SR_GIE 3
`define COTD_SR_CORE_OFF_BIT 4
`define COTD_SR_OSCILLATOR_OFF_BIT 5
`define COTD_SR_V 8
`define COTD_SR_RST 16'h0000

// Unit status register fields.
`define COTD_ST_BUSY 0
`define COTD_ST_DONE 1
`define COTD_ST_UNDEF 2
`define COTD_ST_WROTE 3

// Cycle counts and instruction lengths in main clock cycles and words.
`define COTD_CYC_1 3'h1
`define COTD_CYC_2 3'h2
`define COTD_CYC_3 3'h3
`define COTD_CYC_4 3'h4
`define COTD_CYC_5 3'h5
`define COTD_CYC_6 3'h6
`define COTD_LEN_0 2'h0
`define COTD_LEN_1 2'h1
`define COTD_LEN_2 2'h2
`define COTD_LEN_3 2'h3

`endif

//--- logic/cotd_timing.sv
// Cycle count and word length lookup by format and addressing modes.
`timescale 1ns/1ps
`default_nettype none
`include "cotd_regs.svh"

module cotd_timing (
  input wire cotd_pkg::cotd_desc_t desc_in,
  output cotd_pkg::cotd_time_t time_out
);

  logic mem_dst;
  logic long_src;
  logic [2:0] cyc;
  logic [1:0] wrd;
  logic undef;

  // Timing depends on format, class and modes only, never on the operation.
  always_comb begin
    mem_dst = !(desc_in.dst inside {cotd_pkg::dst_reg,
                                    cotd_pkg::dst_program_counter});
    long_src = desc_in.src inside {cotd_pkg::src_imm, cotd_pkg::src_idx,
                                   cotd_pkg::src_sym, cotd_pkg::src_abs};
    cyc = `COTD_CYC_2;
    wrd = `COTD_LEN_1;
    undef = 1'b0;
    case (desc_in.fmt)
      cotd_pkg::fmt_single: begin
        wrd = long_src ? `COTD_LEN_2 : `COTD_LEN_1;
        case (desc_in.sub)
          cotd_pkg::cls_push: begin
            if (desc_in.src == cotd_pkg::src_reg) cyc = `COTD_CYC_3;
            else if (desc_in.src == cotd_pkg::src_ind) cyc = `COTD_CYC_4;
            else if (desc_in.src == cotd_pkg::src_imm) cyc = `COTD_CYC_4;
            else cyc = `COTD_CYC_5;
          end
          cotd_pkg::cls_call: begin
            if (desc_in.src inside {cotd_pkg::src_reg, cotd_pkg::src_ind})
              cyc = `COTD_CYC_4;
            else cyc = `COTD_CYC_5;
          end
          default: begin
            // Immediate destination is undefined; it is timed as long.
            undef = (desc_in.src == cotd_pkg::src_imm);
            if (desc_in.src == cotd_pkg::src_reg) cyc = `COTD_CYC_1;
            else if (!long_src) cyc = `COTD_CYC_3;
            else cyc = `COTD_CYC_4;
          end
        endcase
      end
      cotd_pkg::fmt_jump: begin
        cyc = `COTD_CYC_2;
        wrd = `COTD_LEN_1;
      end
      cotd_pkg::fmt_double: begin
        if (desc_in.src == cotd_pkg::src_reg) begin
          cyc = mem_dst ? `COTD_CYC_4 :
                (desc_in.dst == cotd_pkg::dst_reg) ? `COTD_CYC_1 :
                `COTD_CYC_2;
          wrd = mem_dst ? `COTD_LEN_2 : `COTD_LEN_1;
        end else if (desc_in.src inside {cotd_pkg::src_ind,
                                         cotd_pkg::src_ainc}) begin
          cyc = mem_dst ? `COTD_CYC_5 :
                (desc_in.dst == cotd_pkg::dst_program_counter &&
                 desc_in.src == cotd_pkg::src_ainc) ? `COTD_CYC_3 :
                `COTD_CYC_2;
          wrd = mem_dst ? `COTD_LEN_2 : `COTD_LEN_1;
        end else if (desc_in.src == cotd_pkg::src_imm) begin
          cyc = mem_dst ? `COTD_CYC_5 :
                (desc_in.dst == cotd_pkg::dst_reg) ? `COTD_CYC_2 :
                `COTD_CYC_3;
          wrd = mem_dst ? `COTD_LEN_3 : `COTD_LEN_2;
        end else begin
          cyc = mem_dst ? `COTD_CYC_6 : `COTD_CYC_3;
          wrd = mem_dst ? `COTD_LEN_3 : `COTD_LEN_2;
        end
      end
      default: begin
        wrd = `COTD_LEN_0;
        case (desc_in.sub)
          cotd_pkg::ev_return_from_interrupt_op: begin
            cyc = `COTD_CYC_5;
            wrd = `COTD_LEN_1;
          end
          cotd_pkg::ev_irq_accept: cyc = `COTD_CYC_6;
          default: cyc = `COTD_CYC_4;
        endcase
      end
    endcase
    time_out = '{valid: 1'b0, cycles: cyc, words: wrd, undef: undef};
  end

endmodule // cotd_timing
`default_nettype wire

//--- logic/cotd_top.sv
// Op unit: swap, sign extend, test and xor with per-instruction timing.
`timescale 1ns/1ps
`default_nettype none
`include "cotd_regs.svh"

// Functional notes
// - Byte swap exchanges bits 15:8 with bits 7:0 and writes back.
// - Byte swap leaves negative, zero, carry and overflow untouched.
// - Sign extend copies bit 7 into bits 15:8, keeps low byte.
// - Sign extend sets N and Z from result, C is not Z, V clear.
// - Test adds all-ones plus one for flags only; destination kept.
// - Test sets N and Z from operand, sets carry, clears overflow.
// - Xor combines source and destination into destination; source kept.
// - Xor sets N from result msb, Z when zero, C is not Z.
// - Xor overflow set only when both operands were negative.
// - Oscillator-off, core-off and interrupt-enable bits never change.
// - Timing follows format, class and modes only, in main clock cycles.
// - Return 5 cycles 1 word; interrupt 6; both resets 4 cycles.
// - Short modes one word: shift 1,3,3; push 3,4,5; call 4,4,5.
// - Long single-operand modes two words: shift 4; push 4 or 5; call 5.
// - Every jump is one word and exactly two cycles.
// - Register source: 1 to register, 2 to counter, 4 two words to memory.
// - Indirect source: 2 cycles, counter 3 if autoincrement, memory 5.
// - Immediate source: register 2, counter 3, memory 5 cycles three words.
// - Indexed-like source: register or counter 3, memory 6, three words.
module cotd_top (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire cotd_pkg::cotd_wb_req_t wb_req_in,
  output cotd_pkg::cotd_wb_rsp_t wb_rsp_out,
  output cotd_pkg::cotd_time_t time_out,
  output logic busy_out
);

  logic ack_q;
  logic [31:0] rdat_q;
  cotd_pkg::cotd_time_t time_q;
  cotd_pkg::cotd_time_t look;
  cotd_pkg::cotd_state_t state_q;
  logic [`COTD_CTRL_W-1:0] ctrl_q;
  logic [15:0] src_q;
  logic [15:0] dst_q;
  logic [15:0] sr_in_q;
  logic [15:0] res_q;
  logic [15:0] sr_out_q;
  logic [2:0] cnt_q;
  logic go_q;
  logic busy_q;
  logic done_q;
  logic undef_q;
  logic wrote_q;
  logic req;
  logic wr_hit;
  logic lock;
  logic start;
  logic commit;

  // Operation result and flag candidates.
  logic [15:0] res_d;
  logic flag_n;
  logic flag_z;
  logic flag_c;
  logic flag_v;
  logic flags_upd;
  logic dst_upd;
  logic [16:0] tsum_w;
  logic [8:0] tsum_b;
  logic [15:0] xr;
  logic byte_md;
  cotd_pkg::cotd_alu_t op;

  // The bus request is live while both cycle and strobe are high.
  assign req = wb_req_in.cyc & wb_req_in.stb;
  // Writes land on the edge at which the master sees ack high.
  assign wr_hit = req & wb_req_in.we & ack_q;
  // Operands and control are frozen while an operation runs.
  assign lock = go_q | busy_q;
  assign start = wr_hit & (wb_req_in.adr == `COTD_OFS_CTRL) &
                 wb_req_in.sel[2] & wb_req_in.dat[`COTD_F_START] & ~lock;
  assign commit = (state_q == cotd_pkg::st_exec) && (cnt_q == `COTD_CYC_1);
  assign op = cotd_pkg::cotd_alu_t'(ctrl_q[`COTD_F_OP]);
  assign byte_md = ctrl_q[`COTD_F_BYTE];

  // Ack and read data live in separate flops so each has one driver.
  assign wb_rsp_out = '{ack: ack_q, dat: rdat_q};
  assign time_out = time_q;
  assign busy_out = busy_q;

  // Timing lookup on the stored descriptor.
  cotd_timing u_timing (
    .desc_in(cotd_pkg::cotd_desc_t'(ctrl_q[`COTD_F_DESC])),
    .time_out(look)
  );

  // Operation datapath; only N, Z, C and V are ever computed.
  always_comb begin
    tsum_w = {1'b0, dst_q} + 17'h0FFFF + 17'h00001;
    tsum_b = {1'b0, dst_q[7:0]} + 9'h0FF + 9'h001;
    xr = src_q ^ dst_q;
    res_d = dst_q;
    flag_n = sr_in_q[`COTD_SR_N];
    flag_z = sr_in_q[`COTD_SR_Z];
    flag_c = sr_in_q[`COTD_SR_C];
    flag_v = sr_in_q[`COTD_SR_V];
    flags_upd = 1'b0;
    dst_upd = 1'b0;
    case (op)
      cotd_pkg::byte_swap_op: begin
        // Word only; flags keep their incoming values.
        res_d = {dst_q[7:0], dst_q[15:8]};
        dst_upd = 1'b1;
      end
      cotd_pkg::sign_extend_op: begin
        res_d = {{8{dst_q[7]}}, dst_q[7:0]};
        dst_upd = 1'b1;
        flags_upd = 1'b1;
        flag_n = res_d[15];
        flag_z = (res_d == 16'h0000);
        flag_c = ~flag_z;
        flag_v = 1'b0;
      end
      cotd_pkg::test_zero_op: begin
        // The sum only feeds the flags, the destination is never written.
        flags_upd = 1'b1;
        if (byte_md) begin
          flag_n = tsum_b[7];
          flag_z = (tsum_b[7:0] == 8'h00);
        end else begin
          flag_n = tsum_w[15];
          flag_z = (tsum_w[15:0] == 16'h0000);
        end
        flag_c = 1'b1;
        flag_v = 1'b0;
      end
      cotd_pkg::xor_op: begin
        dst_upd = 1'b1;
        flags_upd = 1'b1;
        if (byte_md) begin
          // A byte result clears the upper byte of the target.
          res_d = {8'h00, xr[7:0]};
          flag_n = xr[7];
          flag_z = (xr[7:0] == 8'h00);
          flag_v = src_q[7] & dst_q[7];
        end else begin
          res_d = xr;
          flag_n = xr[15];
          flag_z = (xr == 16'h0000);
          flag_v = src_q[15] & dst_q[15];
        end
        flag_c = ~flag_z;
      end
      default: begin
        res_d = dst_q;
      end
    endcase
  end

  // Ack one cycle after the request, dropped the cycle after.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Read data is registered with the ack; unmapped addresses read zero.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdat_q <= 32'h00000000;
    end else if (req & ~ack_q & ~wb_req_in.we) begin
      if (wb_req_in.adr == `COTD_OFS_CTRL) begin
        rdat_q <= {18'h00000, ctrl_q};
      end else if (wb_req_in.adr == `COTD_OFS_SRC) begin
        rdat_q <= {16'h0000, src_q};
      end else if (wb_req_in.adr == `COTD_OFS_DST) begin
        rdat_q <= {16'h0000, dst_q};
      end else if (wb_req_in.adr == `COTD_OFS_SRIN) begin
        rdat_q <= {16'h0000, sr_in_q};
      end else if (wb_req_in.adr == `COTD_OFS_RES) begin
        rdat_q <= {16'h0000, res_q};
      end else if (wb_req_in.adr == `COTD_OFS_SROUT) begin
        rdat_q <= {16'h0000, sr_out_q};
      end else if (wb_req_in.adr == `COTD_OFS_TIME) begin
        rdat_q <= {27'h0000000, time_q.cycles, time_q.words};
      end else if (wb_req_in.adr == `COTD_OFS_STAT) begin
        rdat_q <= {28'h0000000, wrote_q, undef_q, done_q, lock};
      end else begin
        rdat_q <= 32'h00000000;
      end
    end else begin
      rdat_q <= 32'h00000000;
    end
  end

  // Control word; the start bit is a strobe and is not stored.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_q <= `COTD_CTRL_RST;
    end else if (wr_hit && !lock && wb_req_in.adr == `COTD_OFS_CTRL) begin
      if (wb_req_in.sel[0]) ctrl_q[7:0] <= wb_req_in.dat[7:0];
      if (wb_req_in.sel[1]) begin
        ctrl_q[`COTD_CTRL_W-1:8] <= wb_req_in.dat[`COTD_CTRL_W-1:8];
      end
    end
  end

  // Source operand.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      src_q <= 16'h0000;
    end else if (wr_hit && !lock && wb_req_in.adr == `COTD_OFS_SRC) begin
      if (wb_req_in.sel[0]) src_q[7:0] <= wb_req_in.dat[7:0];
      if (wb_req_in.sel[1]) src_q[15:8] <= wb_req_in.dat[15:8];
    end
  end

  // Destination operand, which a committed result does not overwrite;
  // software reads the result register instead.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dst_q <= 16'h0000;
    end else if (wr_hit && !lock && wb_req_in.adr == `COTD_OFS_DST) begin
      if (wb_req_in.sel[0]) dst_q[7:0] <= wb_req_in.dat[7:0];
      if (wb_req_in.sel[1]) dst_q[15:8] <= wb_req_in.dat[15:8];
    end
  end

  // Incoming status word.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sr_in_q <= `COTD_SR_RST;
    end else if (wr_hit && !lock && wb_req_in.adr == `COTD_OFS_SRIN) begin
      if (wb_req_in.sel[0]) sr_in_q[7:0] <= wb_req_in.dat[7:0];
      if (wb_req_in.sel[1]) sr_in_q[15:8] <= wb_req_in.dat[15:8];
    end
  end

  // Start is registered so the lookup sees the freshly written control.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      go_q <= 1'b0;
    end else begin
      go_q <= start;
    end
  end

  // Sequencer: holds busy for exactly the looked-up cycle count.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= cotd_pkg::st_idle;
      cnt_q <= 3'h0;
      busy_q <= 1'b0;
    end else begin
      case (state_q)
        cotd_pkg::st_idle: begin
          if (go_q) begin
            state_q <= cotd_pkg::st_exec;
            cnt_q <= look.cycles;
            busy_q <= 1'b1;
          end
        end
        cotd_pkg::st_exec: begin
          if (commit) begin
            state_q <= cotd_pkg::st_idle;
            cnt_q <= 3'h0;
            busy_q <= 1'b0;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        default: begin
          state_q <= cotd_pkg::st_idle;
        end
      endcase
    end
  end

  // Timing report toward the core, with a one-cycle valid strobe.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      time_q <= '{valid: 1'b0, cycles: 3'h0, words: 2'h0, undef: 1'b0};
    end else if (go_q) begin
      time_q <= '{valid: 1'b1, cycles: look.cycles, words: look.words,
                  undef: look.undef};
    end else begin
      time_q.valid <= 1'b0;
    end
  end

  // Result register: the destination value after the operation. A test
  // passes the operand through unchanged.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      res_q <= 16'h0000;
    end else if (commit) begin
      res_q <= dst_upd ? res_d : dst_q;
    end
  end

  // Outgoing status: mode bits always pass from the incoming word.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sr_out_q <= `COTD_SR_RST;
    end else if (commit) begin
      sr_out_q <= sr_in_q;
      if (flags_upd) begin
        sr_out_q[`COTD_SR_N] <= flag_n;
        sr_out_q[`COTD_SR_Z] <= flag_z;
        sr_out_q[`COTD_SR_C] <= flag_c;
        sr_out_q[`COTD_SR_V] <= flag_v;
      end
    end
  end

  // Sticky done: a commit wins over the clear made by a new start,
  // though the lock keeps the two apart in practice.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      done_q <= 1'b0;
      wrote_q <= 1'b0;
    end else if (commit) begin
      done_q <= 1'b1;
      wrote_q <= dst_upd;
    end else if (go_q) begin
      done_q <= 1'b0;
      wrote_q <= 1'b0;
    end
  end

  // Flags an immediate target on the shift class, which has no
  // defined meaning; the unit still times and runs it.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      undef_q <= 1'b0;
    end else if (go_q) begin
      undef_q <= look.undef;
    end
  end

endmodule // cotd_top
`default_nettype wire

//--- testbench/cotd_top_props.sv
// Concurrent checks on the op unit's bus, timing and busy ports.
`timescale 1ns/1ps
`default_nettype none

module cotd_top_props (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire cotd_pkg::cotd_wb_req_t wb_req_in,
  input wire cotd_pkg::cotd_wb_rsp_t wb_rsp_out,
  input wire cotd_pkg::cotd_time_t time_out,
  input wire logic busy_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  logic [3:0] busy_cnt_q;
  logic start_w;

  // A start is the acked write of bit 16 to the control word while idle.
  assign start_w = wb_req_in.cyc && wb_req_in.stb && wb_req_in.we &&
    wb_rsp_out.ack && wb_req_in.adr == 8'h00 && wb_req_in.dat[16] &&
    wb_req_in.sel[2] && !busy_out;

  // Counts busy cycles so the run length can be judged when it ends.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_cnt_q <= 4'h0;
    end else begin
      busy_cnt_q <= busy_out ? busy_cnt_q + 4'h1 : 4'h0;
    end
  end

  a_ack_one_pulse: assert property (wb_rsp_out.ack |=> !wb_rsp_out.ack)
    else $error("ack stood longer than one cycle");
  a_ack_answers: assert property (
    wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack |=> wb_rsp_out.ack)
    else $error("request not answered in one cycle");
  a_dat_quiet: assert property (!wb_rsp_out.ack |-> wb_rsp_out.dat == 32'h0)
    else $error("read data not zero outside ack");
  a_valid_pulse: assert property (time_out.valid |=> !time_out.valid)
    else $error("timing valid stood longer than one cycle");
  // The start lands at the ack edge; go is registered, so the run shows
  // up two sampled edges later.
  a_start_launch: assert property (
    start_w |-> ##2 (time_out.valid && busy_out))
    else $error("start did not launch the operation");
  a_busy_cause: assert property (
    $rose(busy_out) |-> $past(start_w, 2))
    else $error("busy rose without a start");
  a_busy_length: assert property (
    $fell(busy_out) |-> {1'b0, time_out.cycles} == busy_cnt_q)
    else $error("busy length differs from reported cycles");
  a_cycle_range: assert property (time_out.valid |->
    time_out.cycles inside {[3'h1:3'h6]} &&
    (time_out.cycles != 3'h1 || time_out.words == 2'h1))
    else $error("reported cycle count out of range");

  // Main scenarios worth seeing at least once.
  c_six_cycles: cover property (time_out.valid && time_out.cycles == 3'h6);
  c_busy_end: cover property ($fell(busy_out));
  c_start: cover property (start_w);
endmodule // cotd_top_props

bind cotd_top cotd_top_props u_props (
  .clk_in(clk_in),
  .rst_b_in(rst_b_in),
  .wb_req_in(wb_req_in),
  .wb_rsp_out(wb_rsp_out),
  .time_out(time_out),
  .busy_out(busy_out)
);

`default_nettype wire

//--- testbench/cpu_op_semantics_and_cycle_timing_tb.sv
// Self-checking bench for the op unit: bus access, datapath and timing.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
  bad_count++; $display("mismatch at %0t: got %0h want %0h", $time, got, \
  exp); end end

module cpu_op_semantics_and_cycle_timing_tb;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  cotd_pkg::cotd_wb_req_t req = '0;
  cotd_pkg::cotd_wb_rsp_t rsp;
  cotd_pkg::cotd_time_t tim;
  logic busy;
  logic [31:0] rd;
  int bad_count = 0;
  int samples_checked = 0;

  // Free-running 100 MHz clock.
  always #5 clk_in = ~clk_in;

  cotd_top dut (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .wb_req_in(req),
    .wb_rsp_out(rsp),
    .time_out(tim),
    .busy_out(busy)
  );

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] adr,
      input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_in);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    do begin
      @(posedge clk_in);
      n++;
    end while (rsp.ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      $display("mismatch at %0t: no ack", $time);
    end
    rd = rsp.dat;
    req <= '0;
  endtask

  task automatic rdc(input logic [7:0] adr, input logic [15:0] exp);
    wb(1'b0, adr, 32'h0);
    `CHK(rd[15:0], exp)
  endtask

  // Waits out a run; bounded so a stuck busy cannot hang the bench.
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (2) @(posedge clk_in);
    while (busy !== 1'b0 && n < 50) begin
      @(posedge clk_in);
      n++;
    end
    `CHK(n < 50, 1'b1)
  endtask

  function automatic logic [31:0] ctl(int op, int b, int f, int s, int sm,
      int dm);
    // The descriptor keeps format on top, then class, source and target.
    return {15'h0, 1'b1, 2'h0, 2'(f), 2'(s), 3'(sm), 3'(dm), 1'(b), 3'(op)};
  endfunction

  // Expected {cycles, words} worked out per format and addressing modes.
  function automatic logic [4:0] exp_tw(int f, int s, int sm, int dm);
    int c;
    int w;
    logic mem;
    logic pc;
    mem = dm >= 2;
    pc = dm == 1;
    w = 1;
    case (f)
      0: begin
        w = (sm <= 2) ? 1 : 2;
        if (s == 0) c = (sm == 0) ? 1 : ((sm <= 2) ? 3 : 4);
        else if (s == 1) c = (sm <= 2) ? 3 + sm : ((sm == 3) ? 4 : 5);
        else c = (sm <= 1) ? 4 : 5;
      end
      1: c = 2;
      2: begin
        w = mem ? 2 : 1;
        if (sm == 0) c = mem ? 4 : (pc ? 2 : 1);
        else if (sm <= 2) c = mem ? 5 : ((pc && sm == 2) ? 3 : 2);
        else if (sm == 3) c = mem ? 5 : (pc ? 3 : 2);
        else c = mem ? 6 : 3;
        if (sm >= 3) w = w + 1;
      end
      default: begin
        c = (s == 0) ? 5 : ((s == 1) ? 6 : 4);
        w = (s == 0) ? 1 : 0;
      end
    endcase
    return {3'(c), 2'(w)};
  endfunction

  // Loads operands, starts one op and checks results and untouched inputs.
  task automatic run(int op, int b, int f, logic [15:0] s, logic [15:0] d,
      logic [15:0] si, logic [15:0] r, logic [15:0] so);
    wb(1'b1, 8'h04, {16'h0, s});
    wb(1'b1, 8'h08, {16'h0, d});
    wb(1'b1, 8'h0C, {16'h0, si});
    wb(1'b1, 8'h00, ctl(op, b, f, 0, 0, 0));
    wait_idle();
    rdc(8'h10, r);
    rdc(8'h14, so);
    rdc(8'h04, s);
    rdc(8'h08, d);
  endtask

  // Main sequence.
  initial begin
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rdc(8'h1C, 16'h0);
    wb(1'b1, 8'h20, 32'hFFFF);
    rdc(8'h20, 16'h0);
    wb(1'b1, 8'h10, 32'h1234);
    rdc(8'h10, 16'h0);
    run(1, 0, 0, 0, 16'h40BF, 16'h013F, 16'hBF40, 16'h013F);
    run(2, 0, 0, 0, 16'h0080, 16'h0138, 16'hFF80, 16'h003D);
    run(2, 0, 0, 0, 16'h1200, 16'h013F, 16'h0000, 16'h003A);
    run(3, 0, 0, 0, 16'h8000, 16'h0100, 16'h8000, 16'h0005);
    run(3, 1, 0, 0, 16'h1200, 16'h0004, 16'h1200, 16'h0003);
    run(4, 0, 2, 16'h8001, 16'h8100, 16'h0038, 16'h0101, 16'h0139);
    run(4, 0, 2, 16'h1234, 16'h1234, 16'h0107, 16'h0000, 16'h0002);
    run(4, 1, 2, 16'h0080, 16'hFF81, 16'h0000, 16'h0001, 16'h0101);
    // A write landing while the unit counts down must be dropped.
    wb(1'b1, 8'h08, 32'h5555);
    wb(1'b1, 8'h00, ctl(0, 0, 3, 1, 0, 0));
    wb(1'b1, 8'h08, 32'hAAAA);
    wait_idle();
    rdc(8'h08, 16'h5555);
    for (int f = 0; f < 4; f++)
      for (int s = 0; s < 4; s++)
        for (int sm = 0; sm < 7; sm++)
          for (int dm = 0; dm < 5; dm++)
            if (!((f == 0 && s == 3) || (f inside {1, 2} && s != 0))) begin
              wb(1'b1, 8'h00, ctl(0, 0, f, s, sm, dm));
              wait_idle();
              `CHK({tim.cycles, tim.words}, exp_tw(f, s, sm, dm))
              `CHK(tim.undef, f == 0 && s == 0 && sm == 3)
              rdc(8'h18, {11'h0, exp_tw(f, s, sm, dm)});
            end
    // A reset in mid-run clears every output at once.
    wb(1'b1, 8'h00, ctl(0, 0, 3, 1, 0, 0));
    repeat (2) @(posedge clk_in);
    `CHK(busy, 1'b1)
    rst_b_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    `CHK({busy, tim, rsp}, 41'h0)
    rst_b_in <= 1'b1;
    rdc(8'h1C, 16'h0);
    summarize();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    #500_000;
    bad_count++;
    summarize();
  end
endmodule // cpu_op_semantics_and_cycle_timing_tb

`default_nettype wire
